// File: hdl/rmu_pkg.sv
// package of constants, types and register map for the rotate-and-mask unit
// Summary of operation
// - extract n bits from position b, justify left or right, zero the rest
// - insert a justified n-bit source field at target position b, keep other bits
// - rotate whole word left or right by n, no masking
// - logical shift left or right by n, vacated bits zero
// - clear leftmost or rightmost n bits, keep the rest
// - clear leftmost b bits then shift left by n
// - mask defined by mask_begin and mask_end, derived from a literal mask
// - literal mask valid only as one contiguous nonzero run of ones
// - validate literal mask first; invalid mask reports error code 78
// - record form sets the condition-recording indication
package rmu_pkg;
   localparam int unsigned rmu_w = 32;
   localparam logic [7:0] rmu_err_bad_mask = 8'h4e; // code 78
   localparam logic [7:0] rmu_err_none = 8'h00;
   localparam logic [4:0] rmu_pos_last = 5'h1f;
   localparam logic [31:0] rmu_all_ones = 32'hffffffff;

   // axi4-lite register byte offsets
   localparam logic [7:0] rmu_a_ctrl = 8'h00;
   localparam logic [7:0] rmu_a_src = 8'h04;
   localparam logic [7:0] rmu_a_tgt = 8'h08;
   localparam logic [7:0] rmu_a_mask = 8'h0c;
   localparam logic [7:0] rmu_a_result = 8'h10;
   localparam logic [7:0] rmu_a_status = 8'h14;
   localparam logic [7:0] rmu_a_irq_stat = 8'h18;
   localparam logic [7:0] rmu_a_irq_mask = 8'h1c;

   // ctrl field positions
   localparam int unsigned rmu_f_op = 0;  // 4 bits
   localparam int unsigned rmu_f_n = 8;   // 5 bits
   localparam int unsigned rmu_f_b = 16;  // 5 bits
   localparam int unsigned rmu_f_rec = 24;
   localparam int unsigned rmu_f_go = 31;

   // status and irq bit positions
   localparam int unsigned rmu_s_done = 0;
   localparam int unsigned rmu_s_err = 1;
   localparam int unsigned rmu_s_rec = 2;
   localparam int unsigned rmu_s_code = 8; // 8 bits
   localparam int unsigned rmu_s_mb = 16;  // 5 bits
   localparam int unsigned rmu_s_me = 24;  // 5 bits

   typedef enum logic [3:0] {
      rmu_op_extl = 4'h0,  // extract, left justify
      rmu_op_extr = 4'h1,  // extract, right justify
      rmu_op_insl = 4'h2,  // insert from left-justified field
      rmu_op_insr = 4'h3,  // insert from right-justified field
      rmu_op_rotl = 4'h4,
      rmu_op_rotr = 4'h5,
      rmu_op_shl = 4'h6,
      rmu_op_shr = 4'h7,
      rmu_op_clrl = 4'h8,
      rmu_op_clrr = 4'h9,
      rmu_op_clrsl = 4'ha,
      rmu_op_mask = 4'hb   // rotate then and with literal_bit_mask
   } rmu_op_type;

   typedef struct packed {
      rmu_op_type op;
      logic [4:0] n;
      logic [4:0] b;
      logic record_condition_flag;
   } rmu_cmd_type;

   typedef struct packed {
      logic [31:0] result;
      logic [4:0] mask_begin;
      logic [4:0] mask_end;
      logic mask_ok;
      logic [7:0] err_code;
   } rmu_res_type;
endpackage : rmu_pkg

// File: hdl/rmu_core.sv
// combinational rotate-with-mask datapath with literal mask conversion
module rmu_core (
   input wire rmu_pkg::rmu_cmd_type cmd,
   input wire logic [31:0] src,
   input wire logic [31:0] tgt,
   input wire logic [31:0] literal_bit_mask,
   output rmu_pkg::rmu_res_type res
);
   // rotate left in msb-first numbering equals a left shift toward bit 0
   function automatic logic [31:0] rmu_rotl(input logic [31:0] v, input logic [4:0] s);
      logic [63:0] d;
      d = {v, v} << s;
      return d[63:32];
   endfunction

   // ones from position mb through me, msb-first, wrapping when mb > me
   function automatic logic [31:0] rmu_mask(input logic [4:0] mb, input logic [4:0] me);
      logic [31:0] from_mb;
      logic [31:0] to_me;
      from_mb = rmu_pkg::rmu_all_ones >> mb;
      to_me = rmu_pkg::rmu_all_ones << (rmu_pkg::rmu_pos_last - me);
      return (mb <= me) ? (from_mb & to_me) : (from_mb | to_me);
   endfunction

   logic [4:0] sh;
   logic [4:0] mb;
   logic [4:0] me;
   logic insert;
   logic [31:0] lit;
   logic [31:0] lsb_run;
   logic lit_ok;
   logic [4:0] lit_mb;
   logic [4:0] lit_me;
   logic [31:0] rot;
   logic [31:0] msk;

   // literal mask check: one run only, nonzero; bit 0 maps to vector bit 31
   always_comb begin
      lit = literal_bit_mask;
      lsb_run = lit + (lit & (~lit + 32'h00000001)); // clears the lowest run
      lit_ok = (lit != 32'h00000000) && ((lsb_run & lit) == 32'h00000000);
      lit_mb = 5'h00;
      lit_me = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (lit[i]) begin
            lit_me = 5'(31 - i);
         end
      end
      for (int i = 0; i < 32; i++) begin
         if (lit[i]) begin
            lit_mb = 5'(31 - i);
         end
      end
   end

   // map each operation onto rotate amount, mask_begin and mask_end
   always_comb begin
      sh = 5'h00;
      mb = 5'h00;
      me = rmu_pkg::rmu_pos_last;
      insert = 1'b0;
      case (cmd.op)
         rmu_pkg::rmu_op_extl: begin
            sh = cmd.b;
            me = 5'(cmd.n - 5'h01);
         end
         rmu_pkg::rmu_op_extr: begin
            sh = 5'(cmd.b + cmd.n);
            mb = 5'(-cmd.n);
         end
         rmu_pkg::rmu_op_insl: begin
            sh = 5'(-cmd.b);
            mb = cmd.b;
            me = 5'(cmd.b + cmd.n - 5'h01);
            insert = 1'b1;
         end
         rmu_pkg::rmu_op_insr: begin
            sh = 5'(-(cmd.b + cmd.n));
            mb = cmd.b;
            me = 5'(cmd.b + cmd.n - 5'h01);
            insert = 1'b1;
         end
         rmu_pkg::rmu_op_rotl: sh = cmd.n;
         rmu_pkg::rmu_op_rotr: sh = 5'(-cmd.n);
         rmu_pkg::rmu_op_shl: begin
            sh = cmd.n;
            me = rmu_pkg::rmu_pos_last - cmd.n;
         end
         rmu_pkg::rmu_op_shr: begin
            sh = 5'(-cmd.n);
            mb = cmd.n;
         end
         rmu_pkg::rmu_op_clrl: mb = cmd.n;
         rmu_pkg::rmu_op_clrr: me = rmu_pkg::rmu_pos_last - cmd.n;
         rmu_pkg::rmu_op_clrsl: begin
            sh = cmd.n;
            mb = 5'(cmd.b - cmd.n);
            me = rmu_pkg::rmu_pos_last - cmd.n;
         end
         rmu_pkg::rmu_op_mask: begin
            sh = cmd.b;
            mb = lit_mb;
            me = lit_me;
         end
         default: ;
      endcase
   end

   // rotate, mask, and merge target for insert; n=0 wraps like 32-n read as 0
   always_comb begin
      rot = rmu_rotl(src, sh);
      msk = rmu_mask(mb, me);
      res.mask_begin = mb;
      res.mask_end = me;
      res.mask_ok = 1'b1;
      res.err_code = rmu_pkg::rmu_err_none;
      if (cmd.op == rmu_pkg::rmu_op_mask && !lit_ok) begin
         res.mask_ok = 1'b0;
         res.err_code = rmu_pkg::rmu_err_bad_mask;
         res.mask_begin = 5'h00;
         res.mask_end = 5'h00;
      end
      if (cmd.op == rmu_pkg::rmu_op_rotl || cmd.op == rmu_pkg::rmu_op_rotr) begin
         res.result = rot;
      end else if (insert) begin
         res.result = (rot & msk) | (tgt & ~msk);
      end else begin
         res.result = rot & msk;
      end
   end
endmodule // rmu_core

// File: hdl/rmu_top.sv
// axi4-lite wrapper holding operands, result, status and interrupts
module rmu_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   typedef struct packed {
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      rmu_pkg::rmu_cmd_type cmd;
      logic [31:0] src;
      logic [31:0] tgt;
      logic [31:0] lit;
      logic [31:0] result;
      logic [7:0] code;
      logic [4:0] mb;
      logic [4:0] me;
      logic rec;
      logic [2:0] ist;
      logic [2:0] imask;
      logic launch;
   } rmu_state_type;

   rmu_state_type s_q;
   rmu_state_type s_d;
   rmu_pkg::rmu_res_type res;
   logic do_wr;
   logic do_rd;
   logic go;
   logic [31:0] wm;

   rmu_core u_core (
      .cmd(s_q.cmd),
      .src(s_q.src),
      .tgt(s_q.tgt),
      .literal_bit_mask(s_q.lit),
      .res(res)
   );

   // merge byte lanes of a write into an old word
   function automatic logic [31:0] rmu_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   assign s_axi_awready = !s_q.aw_full && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_full && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign irq = |(s_q.ist & s_q.imask);

   // bus slave, operand registers and one-cycle execution
   always_comb begin
      s_d = s_q;
      go = 1'b0;
      wm = 32'h00000000;
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_full = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_full = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      do_wr = s_q.aw_full && s_q.w_full;
      if (do_wr) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = 2'b00;
         case (s_q.aw_addr)
            rmu_pkg::rmu_a_ctrl: begin
               wm = rmu_merge({1'b0, 6'h00, s_q.cmd.record_condition_flag, 3'h0, s_q.cmd.b,
                  3'h0, s_q.cmd.n, 4'h0, s_q.cmd.op}, s_q.w_data, s_q.w_strb);
               s_d.cmd.op = rmu_pkg::rmu_op_type'(wm[rmu_pkg::rmu_f_op +: 4]);
               s_d.cmd.n = wm[rmu_pkg::rmu_f_n +: 5];
               s_d.cmd.b = wm[rmu_pkg::rmu_f_b +: 5];
               s_d.cmd.record_condition_flag = wm[rmu_pkg::rmu_f_rec];
               go = wm[rmu_pkg::rmu_f_go];
            end
            rmu_pkg::rmu_a_src: s_d.src = rmu_merge(s_q.src, s_q.w_data, s_q.w_strb);
            rmu_pkg::rmu_a_tgt: s_d.tgt = rmu_merge(s_q.tgt, s_q.w_data, s_q.w_strb);
            rmu_pkg::rmu_a_mask: s_d.lit = rmu_merge(s_q.lit, s_q.w_data, s_q.w_strb);
            rmu_pkg::rmu_a_irq_stat: s_d.ist = s_q.ist & ~s_q.w_data[2:0];
            rmu_pkg::rmu_a_irq_mask: s_d.imask = s_q.w_data[2:0];
            rmu_pkg::rmu_a_result, rmu_pkg::rmu_a_status: ;
            default: s_d.bresp = 2'b10;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
      do_rd = s_axi_arvalid && s_axi_arready;
      if (do_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = 2'b00;
         case (s_axi_araddr)
            rmu_pkg::rmu_a_ctrl: s_d.rdata = {7'h00, s_q.cmd.record_condition_flag, 3'h0, s_q.cmd.b,
               3'h0, s_q.cmd.n, 4'h0, s_q.cmd.op};
            rmu_pkg::rmu_a_src: s_d.rdata = s_q.src;
            rmu_pkg::rmu_a_tgt: s_d.rdata = s_q.tgt;
            rmu_pkg::rmu_a_mask: s_d.rdata = s_q.lit;
            rmu_pkg::rmu_a_result: s_d.rdata = s_q.result;
            rmu_pkg::rmu_a_status: s_d.rdata = {3'h0, s_q.me, 3'h0, s_q.mb, s_q.code, 5'h00, s_q.rec,
               s_q.ist[rmu_pkg::rmu_s_err], s_q.ist[rmu_pkg::rmu_s_done]};
            rmu_pkg::rmu_a_irq_stat: s_d.rdata = {29'h0, s_q.ist};
            rmu_pkg::rmu_a_irq_mask: s_d.rdata = {29'h0, s_q.imask};
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = 2'b10;
            end
         endcase
      end
      if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
      // go launches one cycle late so the core reads the updated command
      s_d.launch = go;
      // capture after the clear above, so a hardware set wins over w1c
      if (s_q.launch) begin
         if (res.mask_ok) begin
            s_d.result = res.result;
         end
         s_d.code = res.err_code;
         s_d.mb = res.mask_begin;
         s_d.me = res.mask_end;
         s_d.rec = s_q.cmd.record_condition_flag;
         s_d.ist = s_d.ist | {s_q.cmd.record_condition_flag, !res.mask_ok, 1'b1};
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // rmu_top

// File: testbench/rmu_top_asserts.sv
// checker of the register bus handshake of the rotate-and-mask unit
module rmu_top_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // responses drop the cycle after they are taken
   property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bdrop: assert property (p_bdrop) else $error("write response not released");
   property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rdrop: assert property (p_rdrop) else $error("read response not released");
   // one transfer of each kind at a time
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arblk: assert property (p_arblk) else $error("read address taken while answer pending");
   property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_awblk: assert property (p_awblk) else $error("write taken while answer pending");
   // answer latency as handed over
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   sequence s_wboth; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   property p_blat; s_wboth |-> ##[1:3] s_axi_bvalid; endproperty
   a_blat: assert property (p_blat) else $error("write answer late");
   // reads above 0x1c fail and return zero, mapped aligned reads succeed
   property p_badrd; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
   a_badrd: assert property (p_badrd) else $error("unmapped read not refused");
   property p_okrd; s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h1c && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rresp == 2'h0; endproperty
   a_okrd: assert property (p_okrd) else $error("mapped read refused");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_res: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10);
endmodule // rmu_top_asserts
bind rmu_top rmu_top_asserts u_chk (.*);

// File: testbench/rmu_master.sv
// issue-stage model: register bus master with one write and one read task
module rmu_master (
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   int hangs = 0; // waits that ran out, counted as failures by the bench
   // ready for answers at all times, so no toggle race between calls
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
   end
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (i == 64) hangs++; // no answer within the bound
      resp = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (i == 64) hangs++; // no answer within the bound
      v = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
endmodule // rmu_master

// File: testbench/testbench.sv
// self-checking bench for the rotate-and-mask unit
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [3:0] op;
      logic [4:0] n;
      logic [4:0] b;
      logic [31:0] src;
      logic [31:0] exp;
   } rmu_row_type;
   localparam logic [31:0] pat = 32'h12345678;
   // op, n, b, source, expected result; target all ones, mask 0x00ffff00
   rmu_row_type rows [15] = '{'{4'h0, 5'h08, 5'h04, pat, 32'h23000000},
      '{4'h1, 5'h08, 5'h04, pat, 32'h00000023}, '{4'h1, 5'h01, 5'h00, 32'h80000000, 32'h00000001},
      '{4'h2, 5'h08, 5'h04, pat, 32'hf12fffff}, '{4'h3, 5'h08, 5'h04, pat, 32'hf78fffff},
      '{4'h4, 5'h08, 5'h00, pat, 32'h34567812}, '{4'h5, 5'h08, 5'h00, pat, 32'h78123456},
      '{4'h4, 5'h00, 5'h00, pat, pat}, '{4'h6, 5'h08, 5'h00, pat, 32'h34567800},
      '{4'h7, 5'h08, 5'h00, pat, 32'h00123456}, '{4'h6, 5'h1f, 5'h00, 32'h00000001, 32'h80000000},
      '{4'h8, 5'h08, 5'h00, pat, 32'h00345678}, '{4'h9, 5'h08, 5'h00, pat, 32'h12345600},
      '{4'ha, 5'h04, 5'h08, pat, 32'h03456780}, '{4'hb, 5'h00, 5'h08, pat, 32'h00567800}};
   // literal masks, the status fields and results they must give; bad masks keep the result
   logic [31:0] lits [5] = '{32'h00ffff00, 32'hffffffff, 32'h00000001, 32'h0f0f0000, 32'h0};
   logic [31:0] mres [5] = '{32'h00345600, pat, 32'h00000000, 32'h00000000, 32'h00000000};
   logic [31:0] stats [5] = '{32'h17080000, 32'h1f000000, 32'h1f1f0000, 32'h00004e02, 32'h00004e02};
   logic clk, rstn, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int mismatches, check_count;
   rmu_top DUT (.*);
   rmu_master m (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      mismatches += m.hangs;
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // result appears one cycle after the write answer
   task automatic run(input logic [31:0] ctrl);
      m.wr(8'h00, ctrl, r);
      repeat (3) @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // a run still going after 20000 cycles ends as a failure
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      rstn = 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         m.rd(8'(i * 4), d, r);
         chk(d, 32'h0);
         chk({30'h0, r}, 32'h0);
      end
      m.wr(8'h08, 32'hffffffff, r);
      m.wr(8'h0c, 32'h00ffff00, r);
      foreach (rows[k]) begin
         m.wr(8'h04, rows[k].src, r);
         run({1'b1, 10'h0, rows[k].b, 3'h0, rows[k].n, 4'h0, rows[k].op});
         m.rd(8'h10, d, r);
         chk(d, rows[k].exp);
      end
      // valid, edge and broken masks; errors stay masked from irq
      foreach (lits[k]) begin
         m.wr(8'h0c, lits[k], r);
         run(32'h8000000b);
         m.rd(8'h14, d, r);
         chk(d & 32'h1f1fff02, stats[k]);
         m.rd(8'h10, d, r);
         chk(d, mres[k]);
      end
      chk({31'h0, irq}, 32'h0);
      m.rd(8'h18, d, r);
      chk(d & 32'h2, 32'h2);
      m.wr(8'h1c, 32'h2, r);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      m.wr(8'h18, 32'h7, r);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      m.rd(8'h18, d, r);
      chk(d, 32'h0);
      // record form on a rotate
      run(32'h81000004);
      m.rd(8'h14, d, r);
      chk(d & 32'h4, 32'h4);
      m.rd(8'h18, d, r);
      chk(d & 32'h4, 32'h4);
      // reset in mid-run drops a pending interrupt and all status
      m.wr(8'h1c, 32'h7, r);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      m.rd(8'h14, d, r);
      chk(d, 32'h0);
      // unmapped place refused both ways
      m.wr(8'h40, 32'h1, r);
      chk({30'h0, r}, 32'h2);
      m.rd(8'h40, d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, 32'h2);
      results();
   end
endmodule // testbench
